// *** hw/nsx_exec.sv ***
/*
 * Execution slice: nibble swap, register and literal exclusive-OR and port
 * direction load. Assumes the decoder holds opValid high for one cycle per
 * instruction and waits for done before issuing the next one.
 */
`timescale 1ns/1ps
`default_nettype none
module nsx_exec (
    input wire logic clk, // Core clock, 250 MHz
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic opValid, // Instruction issue strobe
    input wire nsx_pkg::nsx_op_type opCode, // Decoded operation
    input wire logic [nsx_pkg::AddrWidth-1:0] opFile, // File address or port select
    input wire logic opDest, // Destination bit
    input wire logic [nsx_pkg::DataWidth-1:0] opLiteral, // Immediate value
    output logic busy, // Instruction in flight
    output logic done, // One-cycle completion pulse
    output logic [nsx_pkg::DataWidth-1:0] workReg, // Working register
    output logic zeroFlag, // Zero flag
    output logic [nsx_pkg::DataWidth-1:0] portDirA, // Direction of port 6
    output logic [nsx_pkg::DataWidth-1:0] portDirB, // Direction of port 7
    output logic fileWrEn, // File write pulse, mirrors store write
    output logic [nsx_pkg::AddrWidth-1:0] fileWrAddr, // File write address
    output logic [nsx_pkg::DataWidth-1:0] fileWrData // File write data
);
    // ****************************************
    // Reset release
    // ****************************************
    logic rstMeta_q;
    logic rst_n_q;

    // Synchronised release, so every flop leaves reset on the same edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'h0;
            rst_n_q <= 1'h0;
        end else begin
            rstMeta_q <= 1'h1;
            rst_n_q <= rstMeta_q;
        end
    end

    // ****************************************
    // File store
    // ****************************************
    // Store has its own reset so that file operands start known
    nsx_file_if fileBus ();

    nsx_file_mem fileMem (
        .clk(clk),
        .rst_n(rst_n_q),
        .port(fileBus)
    );

    // ****************************************
    // Operand fetch
    // ****************************************
    // Three states give a fixed answer time; instructions never overlap
    typedef enum logic [1:0] {
        StIdle,
        StFetch,
        StExec
    } nsx_state_type;

    nsx_state_type state_q;
    nsx_pkg::nsx_op_type op_q;
    logic [nsx_pkg::AddrWidth-1:0] file_q;
    logic dest_q;
    logic [nsx_pkg::DataWidth-1:0] lit_q;

    // File operands need one cycle for the registered read
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= StIdle;
            op_q <= nsx_pkg::OpNone;
            file_q <= 5'h00;
            dest_q <= 1'h0;
            lit_q <= 8'h00;
        end else begin
            case (state_q)
                StIdle: begin
                    if (opValid) begin
                        op_q <= opCode;
                        file_q <= opFile;
                        dest_q <= opDest;
                        lit_q <= opLiteral;
                        state_q <= StFetch;
                    end
                end
                StFetch: begin
                    state_q <= StExec;
                end
                StExec: begin
                    state_q <= StIdle;
                end
                default: begin
                    state_q <= StIdle;
                end
            endcase
        end
    end

    // Address stays put through fetch and execute, so the read is stable
    assign fileBus.rdAddr = file_q;

    // ****************************************
    // Result
    // ****************************************
    logic [nsx_pkg::DataWidth-1:0] swapRes;
    logic [nsx_pkg::DataWidth-1:0] regXorRes;
    logic [nsx_pkg::DataWidth-1:0] litXorRes;
    logic execNow;

    // Swap and register xor results use the registered read, valid only in the execute cycle
    assign execNow = (state_q == StExec);
    assign swapRes = {fileBus.rdData[nsx_pkg::NibbleLo +: nsx_pkg::NibbleWidth],
                      fileBus.rdData[nsx_pkg::NibbleHi +: nsx_pkg::NibbleWidth]};
    assign regXorRes = workReg ^ fileBus.rdData;
    assign litXorRes = workReg ^ lit_q;

    logic fileWrite;
    logic [nsx_pkg::DataWidth-1:0] fileWrVal;

    // Only file destinations write the store; literal xor never does
    always_comb begin
        fileWrite = 1'h0;
        fileWrVal = swapRes;
        if (execNow && dest_q == nsx_pkg::DestFile) begin
            if (op_q == nsx_pkg::OpNibbleSwap) begin
                fileWrite = 1'h1;
            end else if (op_q == nsx_pkg::OpRegisterXor) begin
                fileWrite = 1'h1;
                fileWrVal = regXorRes;
            end
        end
    end

    assign fileBus.wrEn = fileWrite;
    assign fileBus.wrAddr = file_q;
    assign fileBus.wrData = fileWrVal;

    // ****************************************
    // Working register and zero flag
    // ****************************************
    // Literal xor ignores the destination bit and always lands here
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            workReg <= nsx_pkg::WorkReset;
        end else if (execNow) begin
            case (op_q)
                nsx_pkg::OpNibbleSwap: begin
                    if (dest_q == nsx_pkg::DestWork) begin
                        workReg <= swapRes;
                    end
                end
                nsx_pkg::OpRegisterXor: begin
                    if (dest_q == nsx_pkg::DestWork) begin
                        workReg <= regXorRes;
                    end
                end
                nsx_pkg::OpLiteralXor: begin
                    workReg <= litXorRes;
                end
                default: begin
                end
            endcase
        end
    end

    // Swap and direction load leave the flag alone
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            zeroFlag <= nsx_pkg::ZeroReset;
        end else if (execNow) begin
            if (op_q == nsx_pkg::OpRegisterXor) begin
                zeroFlag <= (regXorRes == 8'h00);
            end else if (op_q == nsx_pkg::OpLiteralXor) begin
                zeroFlag <= (litXorRes == 8'h00);
            end
        end
    end

    // ****************************************
    // Port direction registers
    // ****************************************
    // Reset leaves every pin an input, so nothing drives before software decides
    // Any other select is ignored rather than trapped
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            portDirA <= nsx_pkg::DirReset;
            portDirB <= nsx_pkg::DirReset;
        end else if (execNow && op_q == nsx_pkg::OpPortDirectionLoad) begin
            if (file_q == nsx_pkg::PortSelA) begin
                portDirA <= workReg;
            end
            if (file_q == nsx_pkg::PortSelB) begin
                portDirB <= workReg;
            end
        end
    end

    // ****************************************
    // Handshake and write mirror
    // ****************************************
    // The mirror trails the store write by a cycle so that it leaves a flop
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            busy <= 1'h0;
            done <= 1'h0;
            fileWrEn <= 1'h0;
            fileWrAddr <= 5'h00;
            fileWrData <= 8'h00;
        end else begin
            busy <= (state_q == StIdle) ? opValid : !execNow;
            done <= execNow;
            fileWrEn <= fileWrite;
            fileWrAddr <= file_q;
            fileWrData <= fileWrVal;
        end
    end
endmodule
`default_nettype wire

// *** hw/nsx_pkg.sv ***
/*
 * Constants and types shared by the nibble swap / exclusive-OR / port
 * direction execution slice. Assumes an 8-bit accumulator core that decodes
 * instructions into one of the operation codes below.
 */
// How it works
// - Swap exchanges nibbles, status flags untouched
// - Swap destination bit picks working or file
// - Direction load copies working into port 6/7
// - Register xor updates only the zero flag
// - Register xor destination bit picks working or file
// - Literal xor combines 8-bit immediate with working
package nsx_pkg;

    // ****************************************
    // Widths and codes
    // ****************************************
    localparam int DataWidth = 8;
    localparam int AddrWidth = 5;
    localparam int NibbleLo = 0;
    localparam int NibbleHi = 4;
    localparam int NibbleWidth = 4;
    localparam logic [AddrWidth-1:0] PortSelA = 5'h06;
    localparam logic [AddrWidth-1:0] PortSelB = 5'h07;
    localparam logic DestWork = 1'h0;
    localparam logic DestFile = 1'h1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [DataWidth-1:0] WorkReset = 8'h00;
    localparam logic [DataWidth-1:0] DirReset = 8'hFF;
    localparam logic ZeroReset = 1'h0;
    localparam logic [DataWidth-1:0] FileReset = 8'h00;

    typedef enum logic [2:0] {
        OpNone,
        OpNibbleSwap,
        OpPortDirectionLoad,
        OpLiteralXor,
        OpRegisterXor
    } nsx_op_type;

endpackage

// *** hw/nsx_file_if.sv ***
/*
 * Interface between the execution slice and its file register store.
 * Assumes one clock; write lands on the next edge, read data is registered.
 */
`timescale 1ns/1ps
`default_nettype none
interface nsx_file_if;
    logic [nsx_pkg::AddrWidth-1:0] rdAddr;
    logic [nsx_pkg::DataWidth-1:0] rdData;
    logic wrEn;
    logic [nsx_pkg::AddrWidth-1:0] wrAddr;
    logic [nsx_pkg::DataWidth-1:0] wrData;

    modport core (output rdAddr, input rdData, output wrEn, output wrAddr, output wrData);
    modport mem (input rdAddr, output rdData, input wrEn, input wrAddr, input wrData);
endinterface
`default_nettype wire

// *** hw/nsx_file_mem.sv ***
/*
 * File register store of 32 bytes. Read data comes from a register one cycle
 * after the address. Assumes the reset has already been synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
module nsx_file_mem (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Synchronised reset, active low
    nsx_file_if.mem port // Read and write port
);
    localparam int Depth = 1 << nsx_pkg::AddrWidth;
    localparam int Aw = nsx_pkg::AddrWidth;

    logic [Depth-1:0][nsx_pkg::DataWidth-1:0] mem;

    // Contents clear on reset: this slice has no plain store instruction,
    // so a known start is the only way a program can seed file registers
    for (genvar i = 0; i < Depth; i++) begin : g_word
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mem[i] <= nsx_pkg::FileReset;
            end else if (port.wrEn && port.wrAddr == Aw'(i)) begin
                mem[i] <= port.wrData;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port.rdData <= 8'h00;
        end else begin
            port.rdData <= mem[port.rdAddr];
        end
    end
endmodule
`default_nettype wire

// *** tb/nsx_exec_checker.sv ***
/* Port checks on nsx_exec, bound at the foot.
   Assumes one clock and the two-edge reset release of the design. */
`timescale 1ns/1ps
`default_nettype none
module nsx_exec_checker (
    input wire logic clk, // Clock
    input wire logic arst_n, // Reset
    input wire logic opValid, // Issue
    input wire nsx_pkg::nsx_op_type opCode, // Op
    input wire logic [4:0] opFile, // File
    input wire logic opDest, // Dest
    input wire logic [7:0] opLiteral, // Literal
    input wire logic busy, // Busy
    input wire logic done, // Done
    input wire logic [7:0] workReg, // W
    input wire logic zeroFlag, // Z
    input wire logic [7:0] portDirA, // Port 6
    input wire logic [7:0] portDirB, // Port 7
    input wire logic fileWrEn, // Write
    input wire logic [4:0] fileWrAddr // Address
);
    // ****************
    // Taken requests, a pulse while busy is ignored
    // ****************
    logic go, sw, rx, lx, dl, dlb;
    assign go = opValid && !busy;
    assign sw = go && opCode == nsx_pkg::OpNibbleSwap;
    assign rx = go && opCode == nsx_pkg::OpRegisterXor;
    assign lx = go && opCode == nsx_pkg::OpLiteralXor;
    assign dl = go && opCode == nsx_pkg::OpPortDirectionLoad && opFile == nsx_pkg::PortSelA;
    assign dlb = go && opCode == nsx_pkg::OpPortDirectionLoad && opFile == nsx_pkg::PortSelB;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_done_latency: assert property (go |-> ##3 done) else $error("late done");
    chk_busy_span: assert property (go |=> busy [*2] ##1 !busy) else $error("busy span");
    chk_swap_flag: assert property (sw |-> ##3 zeroFlag === $past(zeroFlag, 3)) else $error("swap flag");
    chk_swap_dest: assert property (sw && opDest |-> ##3 fileWrEn && workReg === $past(workReg, 3))
        else $error("swap dest");
    chk_dir_load: assert property (dl |-> ##3 portDirA === $past(workReg, 3)) else $error("dir load");
    chk_dir_b_load: assert property (dlb |-> ##3 portDirB === $past(workReg, 3)) else $error("dir b load");
    chk_xor_only: assert property (rx |-> ##3 portDirA === $past(portDirA, 3)) else $error("xor side");
    chk_xor_dest: assert property (rx && opDest |-> ##3 fileWrEn && fileWrAddr === $past(opFile, 3))
        else $error("xor dest");
    chk_lit_xor: assert property (lx |-> ##3 workReg === ($past(workReg, 3) ^ $past(opLiteral, 3))
        && zeroFlag === (workReg == 8'h00) && !fileWrEn) else $error("literal xor");
endmodule
bind nsx_exec nsx_exec_checker chk (.clk, .arst_n, .opValid, .opCode, .opFile, .opDest, .opLiteral,
    .busy, .done, .workReg, .zeroFlag, .portDirA, .portDirB, .fileWrEn, .fileWrAddr);
`default_nettype wire

// *** tb/nibble_swap_xor_port_dir_exec_test.sv ***
/* Self-checking bench for nsx_exec: random and corner instructions
   against a small model. Assumes nothing beyond the slice's ports. */
`timescale 1ns/1ps
`default_nettype none
module nibble_swap_xor_port_dir_exec_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic opValid = 1'b0;
    nsx_pkg::nsx_op_type opCode = nsx_pkg::OpNone;
    logic [4:0] opFile = 5'h00;
    logic opDest = 1'b0;
    logic [7:0] opLiteral = 8'h00;
    logic busy, done, zeroFlag, fileWrEn;
    logic [7:0] workReg, portDirA, portDirB, fileWrData, mW, mA, mB;
    logic [4:0] fileWrAddr;
    // Model of the file store, cleared together with the design's reset
    logic [7:0] mF [32];
    logic mZ;
    int nFail = 0;
    int checked = 0;
    nsx_exec DUT (.clk, .arst_n, .opValid, .opCode, .opFile, .opDest, .opLiteral, .busy, .done, .workReg,
        .zeroFlag, .portDirA, .portDirB, .fileWrEn, .fileWrAddr, .fileWrData);
    initial forever #2 clk = ~clk;
    initial begin
        #80000;
        nFail++;
        final_report();
    end
    task automatic final_report();
        if (nFail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmpv(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] result(nsx_pkg::nsx_op_type c, logic [7:0] w, logic [7:0] f, logic [7:0] k);
        case (c)
            nsx_pkg::OpNibbleSwap: return {f[3:0], f[7:4]};
            nsx_pkg::OpRegisterXor: return w ^ f;
            nsx_pkg::OpLiteralXor: return w ^ k;
            default: return w;
        endcase
    endfunction
    task automatic state();
        cmpv("workReg", mW, workReg);
        cmpv("zeroFlag", {7'h00, mZ}, {7'h00, zeroFlag});
        cmpv("portDirA", mA, portDirA);
        cmpv("portDirB", mB, portDirB);
    endtask
    // ****************
    // One instruction; hold 2 repeats the strobe while busy, which must be ignored
    // ****************
    task automatic run(nsx_pkg::nsx_op_type c, logic [4:0] f, logic d, logic [7:0] k, int hold);
        logic [7:0] r;
        logic toFile;
        r = result(c, mW, mF[f], k);
        toFile = d && (c == nsx_pkg::OpNibbleSwap || c == nsx_pkg::OpRegisterXor);
        if (c == nsx_pkg::OpLiteralXor || c == nsx_pkg::OpRegisterXor) mZ = (r == 8'h00);
        if (toFile)
            mF[f] = r;
        else if (c != nsx_pkg::OpNone && c != nsx_pkg::OpPortDirectionLoad)
            mW = r;
        if (c == nsx_pkg::OpPortDirectionLoad && f == nsx_pkg::PortSelA) mA = mW;
        if (c == nsx_pkg::OpPortDirectionLoad && f == nsx_pkg::PortSelB) mB = mW;
        opCode = c;
        opFile = f;
        opDest = d;
        opLiteral = k;
        opValid = 1'b1;
        repeat (hold) @(posedge clk);
        #1;
        cmpv("busy", 8'h01, {7'h00, busy});
        opValid = 1'b0;
        for (int i = 0; i < 8 && done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        cmpv("done", 8'h01, {7'h00, done});
        cmpv("busy", 8'h00, {7'h00, busy});
        state();
        cmpv("fileWrEn", {7'h00, toFile}, {7'h00, fileWrEn});
        if (toFile) cmpv("fileWrAddr", {3'h0, f}, {3'h0, fileWrAddr});
        if (toFile) cmpv("fileWrData", r, fileWrData);
    endtask
    task automatic reset_dut();
        arst_n = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        mW = nsx_pkg::WorkReset;
        mZ = nsx_pkg::ZeroReset;
        mA = nsx_pkg::DirReset;
        mB = nsx_pkg::DirReset;
        for (int i = 0; i < 32; i++)
            mF[i] = nsx_pkg::FileReset;
        state();
        arst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask
    initial begin
        void'($urandom(9924));
        reset_dut();
        run(nsx_pkg::OpNone, 5'h00, 1'b1, 8'hFF, 1);
        run(nsx_pkg::OpLiteralXor, 5'h00, 1'b1, 8'h00, 1);
        run(nsx_pkg::OpLiteralXor, 5'h00, 1'b0, 8'hFF, 2);
        run(nsx_pkg::OpLiteralXor, 5'h00, 1'b0, mW, 1);
        for (int f = 0; f < 32; f++) begin
            run(nsx_pkg::OpLiteralXor, 5'h00, 1'b0, 8'($urandom), 1);
            run(nsx_pkg::OpPortDirectionLoad, 5'(f), 1'b0, 8'h00, 1);
        end
        for (int i = 0; i < 60; i++)
            run(nsx_pkg::nsx_op_type'($urandom % 5), 5'($urandom), 1'($urandom), 8'($urandom), 1 + $urandom % 2);
        run(nsx_pkg::OpNibbleSwap, 5'h03, 1'b0, 8'h00, 1);
        run(nsx_pkg::OpRegisterXor, 5'h1F, 1'b0, 8'h00, 1);
        reset_dut();
        run(nsx_pkg::OpLiteralXor, 5'h00, 1'b0, 8'hA5, 1);
        run(nsx_pkg::OpRegisterXor, 5'h03, 1'b0, 8'h00, 1);
        run(nsx_pkg::OpRegisterXor, 5'h05, 1'b1, 8'h00, 1);
        run(nsx_pkg::OpNibbleSwap, 5'h05, 1'b0, 8'h00, 1);
        run(nsx_pkg::OpNibbleSwap, 5'h05, 1'b1, 8'h00, 2);
        final_report();
    end
endmodule
`default_nettype wire
